// ===== pafs_pin_function_select.v
// What this block does
// - Sixteen-bit direction register, bits 9..0 map onto pins 25 down to 16.
// - Direction bit one drives the pin as output, zero leaves it input.
// - Direction bit matters only while the pin is plain port I/O.
// - Direction bits 15..10 read zero; software writes zero there.
// - Direction register resets to zero, every pin an input.
// - Two sixteen-bit read/write select registers choose each pin's function.
// - First select register bits 15..4 read zero; software writes zero.
// - Pin 25 field bits 3:2: port, address 25, or frame sync; 11 forbidden.
// - Pin 24 field bits 1:0: port, address 24, or transmit data; 11 forbidden.
// - Pin 23 field bits 15:14: port, address 23, or receive data; 11 forbidden.
// - Pin 22 field bits 13:12: port, address 22, or master clock; 11 forbidden.
// - Pin 21 field bits 11:10: port, address 21, or bit clock; 11 forbidden.
// - Pins 20..16 use bits 8,6,4,2,0: zero port, one address output.
// - Second select register bits 9,7,5,3,1 read zero; software writes zero.
`timescale 1ns/100ps
`include "pafs_regs.vh"

module pafs_pin_function_select #(
    parameter PIN_COUNT = 10
) (
    input wire aclk, // System clock, 25 MHz.
    input wire aresetn, // Synchronous reset, active low.
    input wire [11:0] s_axi_awaddr, // Write address.
    input wire s_axi_awvalid, // Write address valid.
    output wire s_axi_awready, // Write address ready.
    input wire [31:0] s_axi_wdata, // Write data.
    input wire [3:0] s_axi_wstrb, // Write byte strobes.
    input wire s_axi_wvalid, // Write data valid.
    output wire s_axi_wready, // Write data ready.
    output wire [1:0] s_axi_bresp, // Write response.
    output wire s_axi_bvalid, // Write response valid.
    input wire s_axi_bready, // Write response ready.
    input wire [11:0] s_axi_araddr, // Read address.
    input wire s_axi_arvalid, // Read address valid.
    output wire s_axi_arready, // Read address ready.
    output wire [31:0] s_axi_rdata, // Read data.
    output wire [1:0] s_axi_rresp, // Read response.
    output wire s_axi_rvalid, // Read data valid.
    input wire s_axi_rready, // Read data ready.
    input wire [PIN_COUNT-1:0] pad_in, // Pad levels, pin 16 at bit 0.
    output wire [PIN_COUNT-1:0] pad_out, // Pad drive values.
    output wire [PIN_COUNT-1:0] pad_oe, // Pad output enables, high drives.
    input wire [PIN_COUNT-1:0] port_out_data, // Port data to drive.
    output wire [PIN_COUNT-1:0] port_in_data, // Synchronised pad levels to the port.
    input wire [PIN_COUNT-1:0] bus_addr_hi, // Bus controller address bits 25..16.
    input wire serial_frame_sync_out, // Frame sync from the serial interface.
    input wire serial_frame_sync_oe, // Frame sync drive enable.
    output wire serial_frame_sync_in, // Frame sync level to the serial interface.
    input wire serial_transmit_data, // Transmit data from the serial interface.
    output wire serial_receive_data, // Receive data to the serial interface.
    output wire serial_master_clock, // Master clock to the serial interface.
    input wire serial_bit_clock_out, // Bit clock from the serial interface.
    input wire serial_bit_clock_oe, // Bit clock drive enable.
    output wire serial_bit_clock_in // Bit clock level to the serial interface.
);

    reg [15:0] direction_ff;
    reg [15:0] select_1_ff;
    reg [15:0] select_2_ff;
    reg [PIN_COUNT-1:0] sync1_ff;
    reg [PIN_COUNT-1:0] sync2_ff;
    reg [PIN_COUNT-1:0] pad_out_ff;
    reg [PIN_COUNT-1:0] pad_oe_ff;
    reg [PIN_COUNT-1:0] port_in_ff;
    reg fs_in_ff;
    reg rxd_ff;
    reg mclk_ff;
    reg sck_in_ff;

    reg awready_ff;
    reg wready_ff;
    reg aw_held_ff;
    reg w_held_ff;
    reg [11:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg arready_ff;
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;

    reg [15:0] nxt_direction;
    reg [15:0] nxt_select_1;
    reg [15:0] nxt_select_2;
    reg [15:0] merged;
    reg [PIN_COUNT-1:0] nxt_pad_out;
    reg [PIN_COUNT-1:0] nxt_pad_oe;
    reg [31:0] nxt_rdata;
    reg [1:0] nxt_rresp;
    reg write_hit;
    integer i;

    // Two-bit function code of every pin, pin 16 in bits 1:0.
    wire [2*PIN_COUNT-1:0] mode_vec;
    assign mode_vec = {select_1_ff[3:0], select_2_ff[15:10],
                       1'b0, select_2_ff[8], 1'b0, select_2_ff[6],
                       1'b0, select_2_ff[4], 1'b0, select_2_ff[2],
                       1'b0, select_2_ff[0]};

    // Handshakes completing at this edge; a write commits once both halves are held.
    wire aw_take = s_axi_awvalid & awready_ff;
    wire w_take = s_axi_wvalid & wready_ff;
    wire ar_take = s_axi_arvalid & arready_ff;
    wire do_write = aw_held_ff & w_held_ff & ~bvalid_ff;

    // Apply byte strobes to a register's current value.
    function [15:0] strobe_merge;
        input [15:0] old_val;
        input [31:0] data;
        input [3:0] strb;
        begin
            strobe_merge[7:0] = strb[0] ? data[7:0] : old_val[7:0];
            strobe_merge[15:8] = strb[1] ? data[15:8] : old_val[15:8];
        end
    endfunction

    // A two-bit field written with the forbidden code keeps its old value.
    function [1:0] field_guard;
        input [1:0] old_val;
        input [1:0] new_val;
        begin
            field_guard = (new_val == `PAFS_MODE_FORBIDDEN) ? old_val : new_val;
        end
    endfunction

    // Register write path.
    always @* begin
        nxt_direction = direction_ff;
        nxt_select_1 = select_1_ff;
        nxt_select_2 = select_2_ff;
        merged = 16'h0000;
        write_hit = 1'b1;
        case (awaddr_ff & 12'hFFC)
            `PAFS_OFF_DIRECTION: begin
                merged = strobe_merge(direction_ff, wdata_ff, wstrb_ff);
                nxt_direction = merged & `PAFS_MASK_DIRECTION;
            end
            `PAFS_OFF_SELECT_1: begin
                merged = strobe_merge(select_1_ff, wdata_ff, wstrb_ff) & `PAFS_MASK_SELECT_1;
                nxt_select_1 = merged;
                nxt_select_1[`PAFS_POS_PIN25+1:`PAFS_POS_PIN25] = field_guard(
                    select_1_ff[`PAFS_POS_PIN25+1:`PAFS_POS_PIN25],
                    merged[`PAFS_POS_PIN25+1:`PAFS_POS_PIN25]);
                nxt_select_1[`PAFS_POS_PIN24+1:`PAFS_POS_PIN24] = field_guard(
                    select_1_ff[`PAFS_POS_PIN24+1:`PAFS_POS_PIN24],
                    merged[`PAFS_POS_PIN24+1:`PAFS_POS_PIN24]);
            end
            `PAFS_OFF_SELECT_2: begin
                merged = strobe_merge(select_2_ff, wdata_ff, wstrb_ff) & `PAFS_MASK_SELECT_2;
                nxt_select_2 = merged;
                nxt_select_2[`PAFS_POS_PIN23+1:`PAFS_POS_PIN23] = field_guard(
                    select_2_ff[`PAFS_POS_PIN23+1:`PAFS_POS_PIN23],
                    merged[`PAFS_POS_PIN23+1:`PAFS_POS_PIN23]);
                nxt_select_2[`PAFS_POS_PIN22+1:`PAFS_POS_PIN22] = field_guard(
                    select_2_ff[`PAFS_POS_PIN22+1:`PAFS_POS_PIN22],
                    merged[`PAFS_POS_PIN22+1:`PAFS_POS_PIN22]);
                nxt_select_2[`PAFS_POS_PIN21+1:`PAFS_POS_PIN21] = field_guard(
                    select_2_ff[`PAFS_POS_PIN21+1:`PAFS_POS_PIN21],
                    merged[`PAFS_POS_PIN21+1:`PAFS_POS_PIN21]);
            end
            `PAFS_OFF_PIN_LEVEL: begin
                // The pin-level word is read-only, so a write leaves every register alone.
                write_hit = 1'b1;
            end
            default: begin
                write_hit = 1'b0;
            end
        endcase
    end

    // Register read path.
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `PAFS_RESP_OKAY;
        case (s_axi_araddr & 12'hFFC)
            `PAFS_OFF_DIRECTION: begin
                nxt_rdata[15:0] = direction_ff;
            end
            `PAFS_OFF_SELECT_1: begin
                nxt_rdata[15:0] = select_1_ff;
            end
            `PAFS_OFF_SELECT_2: begin
                nxt_rdata[15:0] = select_2_ff;
            end
            `PAFS_OFF_PIN_LEVEL: begin
                nxt_rdata[PIN_COUNT-1:0] = sync2_ff;
            end
            default: begin
                nxt_rresp = `PAFS_RESP_SLVERR;
            end
        endcase
    end

    // Pad multiplexer: port I/O, bus address output, or serial function.
    always @* begin
        for (i = 0; i < PIN_COUNT; i = i + 1) begin
            nxt_pad_out[i] = port_out_data[i];
            nxt_pad_oe[i] = direction_ff[i];
            if (mode_vec[2*i +: 2] == `PAFS_MODE_ADDR) begin
                nxt_pad_out[i] = bus_addr_hi[i];
                nxt_pad_oe[i] = 1'b1;
            end
        end
        if (mode_vec[19:18] == `PAFS_MODE_SERIAL) begin
            nxt_pad_out[9] = serial_frame_sync_out;
            nxt_pad_oe[9] = serial_frame_sync_oe;
        end
        if (mode_vec[17:16] == `PAFS_MODE_SERIAL) begin
            nxt_pad_out[8] = serial_transmit_data;
            nxt_pad_oe[8] = 1'b1;
        end
        // Receive-only serial pins are released so that the far end can drive them.
        if (mode_vec[15:14] == `PAFS_MODE_SERIAL) begin
            nxt_pad_out[7] = 1'b0;
            nxt_pad_oe[7] = 1'b0;
        end
        if (mode_vec[13:12] == `PAFS_MODE_SERIAL) begin
            nxt_pad_out[6] = 1'b0;
            nxt_pad_oe[6] = 1'b0;
        end
        if (mode_vec[11:10] == `PAFS_MODE_SERIAL) begin
            nxt_pad_out[5] = serial_bit_clock_out;
            nxt_pad_oe[5] = serial_bit_clock_oe;
        end
    end

    // Registers, pads and the pad input synchroniser.
    always @(posedge aclk) begin
        if (!aresetn) begin
            direction_ff <= `PAFS_RST_DIRECTION;
            select_1_ff <= `PAFS_RST_SELECT_1;
            select_2_ff <= `PAFS_RST_SELECT_2;
            sync1_ff <= {PIN_COUNT{1'b0}};
            sync2_ff <= {PIN_COUNT{1'b0}};
            pad_out_ff <= {PIN_COUNT{1'b0}};
            pad_oe_ff <= {PIN_COUNT{1'b0}};
            port_in_ff <= {PIN_COUNT{1'b0}};
            fs_in_ff <= 1'b0;
            rxd_ff <= 1'b0;
            mclk_ff <= 1'b0;
            sck_in_ff <= 1'b0;
        end else begin
            if (do_write) begin
                direction_ff <= nxt_direction;
                select_1_ff <= nxt_select_1;
                select_2_ff <= nxt_select_2;
            end
            // Only the second stage feeds logic, so a metastable first stage never spreads.
            sync1_ff <= pad_in;
            sync2_ff <= sync1_ff;
            pad_out_ff <= nxt_pad_out;
            pad_oe_ff <= nxt_pad_oe;
            port_in_ff <= sync2_ff;
            // A serial input reads zero unless its pin is in serial mode.
            fs_in_ff <= (mode_vec[19:18] == `PAFS_MODE_SERIAL) & sync2_ff[9];
            rxd_ff <= (mode_vec[15:14] == `PAFS_MODE_SERIAL) & sync2_ff[7];
            mclk_ff <= (mode_vec[13:12] == `PAFS_MODE_SERIAL) & sync2_ff[6];
            sck_in_ff <= (mode_vec[11:10] == `PAFS_MODE_SERIAL) & sync2_ff[5];
        end
    end

    // AXI4-Lite write channel: address and data taken in either order.
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `PAFS_RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr;
                aw_held_ff <= 1'b1;
                awready_ff <= 1'b0;
            end else if (!aw_held_ff && !bvalid_ff) begin
                awready_ff <= 1'b1;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                w_held_ff <= 1'b1;
                wready_ff <= 1'b0;
            end else if (!w_held_ff && !bvalid_ff) begin
                wready_ff <= 1'b1;
            end
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= write_hit ? `PAFS_RESP_OKAY : `PAFS_RESP_SLVERR;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel: one read at a time, answered the cycle after.
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `PAFS_RESP_OKAY;
        end else begin
            if (ar_take) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= nxt_rdata;
                rresp_ff <= nxt_rresp;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end else if (!rvalid_ff) begin
                arready_ff <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign pad_out = pad_out_ff;
    assign pad_oe = pad_oe_ff;
    assign port_in_data = port_in_ff;
    assign serial_frame_sync_in = fs_in_ff;
    assign serial_receive_data = rxd_ff;
    assign serial_master_clock = mclk_ff;
    assign serial_bit_clock_in = sck_in_ff;

endmodule // pafs_pin_function_select

// ===== pafs_regs.vh
`ifndef PAFS_REGS_VH
`define PAFS_REGS_VH

// Register byte offsets on the AXI4-Lite bus.
`define PAFS_OFF_DIRECTION 12'h000
`define PAFS_OFF_SELECT_1 12'h004
`define PAFS_OFF_SELECT_2 12'h008
`define PAFS_OFF_PIN_LEVEL 12'h00C

// Reset values.
`define PAFS_RST_DIRECTION 16'h0000
`define PAFS_RST_SELECT_1 16'h0000
`define PAFS_RST_SELECT_2 16'h0000

// Writable bits of each register; every other bit is reserved and reads as zero.
`define PAFS_MASK_DIRECTION 16'h03FF
`define PAFS_MASK_SELECT_1 16'h000F
`define PAFS_MASK_SELECT_2 16'hFD55

// Field positions of the two-bit selects.
`define PAFS_POS_PIN25 2
`define PAFS_POS_PIN24 0
`define PAFS_POS_PIN23 14
`define PAFS_POS_PIN22 12
`define PAFS_POS_PIN21 10

// Function codes of a pin select field.
`define PAFS_MODE_PORT 2'h0
`define PAFS_MODE_ADDR 2'h1
`define PAFS_MODE_SERIAL 2'h2
`define PAFS_MODE_FORBIDDEN 2'h3

// AXI response codes.
`define PAFS_RESP_OKAY 2'h0
`define PAFS_RESP_SLVERR 2'h2

`endif

// ===== pafs_pad_model.sv
`timescale 1ns/100ps
module pafs_pad_model #(
    parameter PIN_COUNT = 10
) (
    input logic [PIN_COUNT-1:0] pad_out, // Drive values from the block.
    input logic [PIN_COUNT-1:0] pad_oe, // Drive enables from the block.
    input logic [PIN_COUNT-1:0] ext_level, // Board level on a released pin.
    output logic [PIN_COUNT-1:0] pad_in // Level seen at each pad.
);
    // A released pin shows the board level, never the last driven value.
    assign pad_in = (pad_out & pad_oe) | (ext_level & ~pad_oe);
endmodule // pafs_pad_model

// ===== pafs_checker_assertions.sv
`timescale 1ns/100ps
module pafs_checker #(
    parameter PIN_COUNT = 10
) (
    input logic aclk, // Clock.
    input logic aresetn, // Reset.
    input logic s_axi_awvalid, // Bus.
    input logic s_axi_awready, // Bus.
    input logic s_axi_wvalid, // Bus.
    input logic s_axi_wready, // Bus.
    input logic [1:0] s_axi_bresp, // Bus.
    input logic s_axi_bvalid, // Bus.
    input logic s_axi_bready, // Bus.
    input logic s_axi_arvalid, // Bus.
    input logic s_axi_arready, // Bus.
    input logic [31:0] s_axi_rdata, // Bus.
    input logic s_axi_rvalid, // Bus.
    input logic s_axi_rready, // Bus.
    input logic [PIN_COUNT-1:0] pad_in, // Pads.
    input logic [PIN_COUNT-1:0] pad_oe, // Pads.
    input logic serial_frame_sync_in, // Serial.
    input logic serial_receive_data, // Serial.
    input logic serial_master_clock, // Serial.
    input logic serial_bit_clock_in // Serial.
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RST_IDLE: assert property ($rose(aresetn) |-> pad_oe == '0 && !s_axi_bvalid)
        else $error("pads driven or response pending after reset");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_WR_RECOVER: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready)
        else $error("write channel not reopened");
    AST_RXD: assert property (serial_receive_data |-> $past(pad_in[7], 3))
        else $error("receive data without pad level");
    AST_MCLK: assert property (serial_master_clock |-> $past(pad_in[6], 3))
        else $error("master clock without pad level");
    AST_SCK: assert property (serial_bit_clock_in |-> $past(pad_in[5], 3))
        else $error("bit clock without pad level");
    AST_FSYNC: assert property (serial_frame_sync_in |-> $past(pad_in[9], 3))
        else $error("frame sync without pad level");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (serial_receive_data);
endmodule // pafs_checker

bind pafs_pin_function_select pafs_checker #(.PIN_COUNT(PIN_COUNT)) u_chk (.*);

// ===== pafs_tb.sv
`timescale 1ns/100ps
`include "pafs_regs.vh"
module tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] pad_in, pad_out, pad_oe, port_out_data, port_in_data, bus_addr_hi, ext_level;
    logic serial_frame_sync_out, serial_frame_sync_oe, serial_frame_sync_in;
    logic serial_transmit_data, serial_receive_data, serial_master_clock;
    logic serial_bit_clock_out, serial_bit_clock_oe, serial_bit_clock_in;
    int num_errors = 0;
    int checks = 0;

    pafs_pin_function_select dut (.*);
    pafs_pad_model u_pads (.*);

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The response ready rises late so that the block must hold its answer.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n == 3) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk($sformatf("bresp %h", a), 32'(er), 32'(s_axi_bresp));
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n == 3) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk($sformatf("rdata %h", a), ed, s_axi_rdata);
        chk($sformatf("rresp %h", a), 32'(er), 32'(s_axi_rresp));
    endtask

    task automatic settle;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic t_reset;
        rd(`PAFS_OFF_DIRECTION, 32'h00000000, `PAFS_RESP_OKAY);
        rd(`PAFS_OFF_SELECT_1, 32'h00000000, `PAFS_RESP_OKAY);
        rd(`PAFS_OFF_SELECT_2, 32'h00000000, `PAFS_RESP_OKAY);
        chk("pad_oe", 32'h00000000, 32'(pad_oe));
    endtask

    task automatic t_reserved;
        wr(`PAFS_OFF_DIRECTION, 32'h0000FFFF, `PAFS_RESP_OKAY);
        rd(`PAFS_OFF_DIRECTION, 32'h000003FF, `PAFS_RESP_OKAY);
        wr(`PAFS_OFF_SELECT_1, 32'h0000FFFF, `PAFS_RESP_OKAY);
        rd(`PAFS_OFF_SELECT_1, 32'h00000000, `PAFS_RESP_OKAY);
        wr(`PAFS_OFF_SELECT_2, 32'h0000FFFF, `PAFS_RESP_OKAY);
        rd(`PAFS_OFF_SELECT_2, 32'h00000155, `PAFS_RESP_OKAY);
        wr(`PAFS_OFF_SELECT_2, 32'h00000000, `PAFS_RESP_OKAY);
    endtask

    task automatic t_port;
        @(posedge aclk);
        port_out_data <= 10'h2A5;
        ext_level <= 10'h1C3;
        wr(`PAFS_OFF_DIRECTION, 32'h00000201, `PAFS_RESP_OKAY);
        settle;
        chk("pad_oe", 32'h00000201, 32'(pad_oe));
        chk("pad_out", 32'h00000201, 32'(pad_out & pad_oe));
        chk("port_in_data", 32'h000003C3, 32'(port_in_data));
        rd(`PAFS_OFF_PIN_LEVEL, 32'h000003C3, `PAFS_RESP_OKAY);
    endtask

    task automatic t_addr;
        @(posedge aclk);
        bus_addr_hi <= 10'h35A;
        wr(`PAFS_OFF_SELECT_1, 32'h00000005, `PAFS_RESP_OKAY);
        wr(`PAFS_OFF_SELECT_2, 32'h00005555, `PAFS_RESP_OKAY);
        rd(`PAFS_OFF_SELECT_2, 32'h00005555, `PAFS_RESP_OKAY);
        settle;
        chk("pad_oe", 32'h000003FF, 32'(pad_oe));
        chk("pad_out", 32'h0000035A, 32'(pad_out));
    endtask

    task automatic t_serial;
        @(posedge aclk);
        port_out_data <= 10'h015;
        ext_level <= 10'h0E0;
        {serial_frame_sync_out, serial_frame_sync_oe, serial_transmit_data} <= 3'b111;
        {serial_bit_clock_out, serial_bit_clock_oe} <= 2'b01;
        wr(`PAFS_OFF_DIRECTION, 32'h000003FF, `PAFS_RESP_OKAY);
        wr(`PAFS_OFF_SELECT_1, 32'h0000000A, `PAFS_RESP_OKAY);
        wr(`PAFS_OFF_SELECT_1, 32'h0000000F, `PAFS_RESP_OKAY);
        wr(`PAFS_OFF_SELECT_2, 32'h0000A800, `PAFS_RESP_OKAY);
        rd(`PAFS_OFF_SELECT_1, 32'h0000000A, `PAFS_RESP_OKAY);
        settle;
        chk("pad_oe", 32'h0000033F, 32'(pad_oe));
        chk("pad_out", 32'h00000315, 32'(pad_out & pad_oe));
        chk("serial in", 32'h0000000E, 32'({serial_frame_sync_in, serial_receive_data,
            serial_master_clock, serial_bit_clock_in}));
        @(posedge aclk);
        serial_bit_clock_oe <= 1'b0;
        ext_level <= 10'h060;
        settle;
        chk("pad_oe", 32'h0000031F, 32'(pad_oe));
        chk("serial in", 32'h0000000B, 32'({serial_frame_sync_in, serial_receive_data,
            serial_master_clock, serial_bit_clock_in}));
    endtask

    task automatic t_unmapped;
        wr(12'h010, 32'h0000FFFF, `PAFS_RESP_SLVERR);
        rd(12'h010, 32'h00000000, `PAFS_RESP_SLVERR);
        wr(`PAFS_OFF_PIN_LEVEL, 32'h00000000, `PAFS_RESP_OKAY);
        rd(`PAFS_OFF_DIRECTION, 32'h000003FF, `PAFS_RESP_OKAY);
        // Only the low byte strobe is set, so bits 9 and 8 keep their value.
        @(posedge aclk);
        s_axi_wstrb <= 4'h1;
        wr(`PAFS_OFF_DIRECTION, 32'h00000000, `PAFS_RESP_OKAY);
        rd(`PAFS_OFF_DIRECTION, 32'h00000300, `PAFS_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
    endtask

    task automatic complete_run;
        if (num_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {serial_frame_sync_out, serial_frame_sync_oe, serial_transmit_data} = '0;
        {serial_bit_clock_out, serial_bit_clock_oe} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {port_out_data, bus_addr_hi, ext_level} = '0;
        s_axi_wstrb = 4'hF;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_reserved;
        t_port;
        t_addr;
        t_serial;
        t_unmapped;
        // A second reset in mid-run must clear the values written above.
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        complete_run;
    end

    initial begin
        repeat (3000) @(posedge aclk);
        num_errors++;
        complete_run;
    end
endmodule // tb
